// [logic/lth_params.svh]
// Purpose: constants for the light threshold and data register block
// Assumes: 25 MHz system clock
// Notes: offsets are byte register addresses on the serial bus
// Overview of operation
// - A light result at or above the upper threshold raises the light flag and, in OR mode, the interrupt.
// - The upper threshold is bits 7..4 of register 0x06 as its low nibble and register 0x07 as its high byte.
// - After reset register 0x06 reads 0xf0 and register 0x07 reads 0xff.
// - Register 0x08 holds the 8-bit proximity result and ignores host writes.
// - All result registers refresh at the end of each conversion and read 0x00 after reset.
// - Light result bits 7..0 read at 0x09 and bits 11..8 in the low nibble of 0x0a.
// - The light result is twelve bits wide, bit 0 to bit 11.
// - Bit 1 of register 0x01 picks the low (0) or high (1) light range.
// - Every conversion integrates for a fixed 100 ms.
// - The device answers on the serial bus only at 7-bit address 0b1000100.
// - The lower threshold is register 0x05 plus bits 3..0 of 0x06; a result at or below it raises the light flag.
// - The light flag at bit 3 of register 0x02 stays set until the host writes a zero to it.
// - The flag rises only after 1, 4, 8 or 16 consecutive results outside the window, per a two-bit field.
// - Bit 0 of register 0x02 picks OR (0) or AND (1) of the two flags onto the open-drain interrupt pin.
`ifndef LTH_PARAMS_SVH
`define LTH_PARAMS_SVH

// ****************************************
// addresses and reset values
// ****************************************
`define LTH_I2C_ADDR 7'h44
`define LTH_ADDR_CFG 8'h01
`define LTH_ADDR_INTR 8'h02
`define LTH_ADDR_PROX_LO 8'h03
`define LTH_ADDR_PROX_HI 8'h04
`define LTH_ADDR_LT_LOW 8'h05
`define LTH_ADDR_NIBBLES 8'h06
`define LTH_ADDR_UT_HIGH 8'h07
`define LTH_ADDR_PROX 8'h08
`define LTH_ADDR_LIGHT_LO 8'h09
`define LTH_ADDR_LIGHT_HI 8'h0a
`define LTH_RST_ZERO 8'h00
`define LTH_RST_NIBBLES 8'hf0
`define LTH_RST_UT_HIGH 8'hff
`define LTH_RST_PROX_HI 8'hff

// ****************************************
// field positions
// ****************************************
`define LTH_CFG_RANGE 1
`define LTH_CFG_IRMODE 0
`define LTH_INT_CTRL 0
`define LTH_INT_LFLAG 3
`define LTH_INT_PFLAG 7

// ****************************************
// timing
// ****************************************
`define LTH_INTEG_MS 100
`define LTH_CLK_HZ 25000000
`define LTH_INTEG_CYCLES (`LTH_INTEG_MS * (`LTH_CLK_HZ / 1000))

`endif

// [logic/lth_pkg.sv]
// Purpose: shared types of the light threshold block
// Assumes: nothing
// Notes: none
`default_nettype none
package lth_pkg;
    typedef enum logic [3:0] {
        LTH_IDLE,
        LTH_ADDR,
        LTH_ADDR_ACK,
        LTH_REG,
        LTH_REG_ACK,
        LTH_WDATA,
        LTH_WDATA_ACK,
        LTH_RDATA,
        LTH_RDATA_ACK
    } lth_i2c_state_e;
    typedef logic [1:0] lth_persist_t;
endpackage
`default_nettype wire

// [logic/lth_flt_if.sv]
// Purpose: link between the register block and a persistence filter
// Assumes: one clock
// Notes: hit is a one-cycle pulse on conv_done
`timescale 1ns/1ps
`default_nettype none
interface lth_flt_if;
    import lth_pkg::*;
    logic conv_done;
    logic cond;
    lth_persist_t sel;
    logic hit;
    modport ctl (output conv_done, output cond, output sel, input hit);
    modport flt (input conv_done, input cond, input sel, output hit);
endinterface
`default_nettype wire

// [logic/lth_persist.sv]
// Purpose: counts consecutive conversions that meet a condition
// Assumes: conv_done is a one-cycle pulse
// Notes: count holds once the needed number is reached
`timescale 1ns/1ps
`default_nettype none
module lth_persist
    import lth_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // filter link
    lth_flt_if.flt f
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [4:0] need;
    logic [4:0] inc;

    // ****************************************
    // count and hit
    // ****************************************
    always_comb begin
        unique case (f.sel)
            2'h0: need = 5'h01;
            2'h1: need = 5'h04;
            2'h2: need = 5'h08;
            2'h3: need = 5'h10;
        endcase
        inc = cnt_q + 5'h01;
        f.hit = f.conv_done && f.cond && (inc >= need);
        cnt_d = cnt_q;
        if (f.conv_done) begin
            if (!f.cond) begin
                cnt_d = 5'h00;
            end else if (inc < need) begin
                cnt_d = inc;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    a_persist_count: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        f.hit |-> f.cond && ({1'b0, cnt_q} + 6'h01 >= {1'b0, need}))
        else $error("filter hit before count reached");
endmodule // lth_persist
`default_nettype wire

// [logic/lth_light_regs.sv]
// Purpose: serial-bus register file, conversion timing and thresholds
// Assumes: front-end results are valid in the cycle o_conv_done is high
// Notes: open-drain pins use an active-low output enable
`timescale 1ns/1ps
`default_nettype none
`include "lth_params.svh"
module lth_light_regs
    import lth_pkg::*;
#(
    parameter int unsigned P_INTEG_CYCLES = `LTH_INTEG_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // serial bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    // analog front end
    input wire logic [11:0] i_light_adc,
    input wire logic [7:0] i_prox_adc,
    output logic o_conv_done,
    output logic o_light_range_high,
    output logic o_light_ir_mode,
    // interrupt pin
    output logic o_int_out,
    output logic o_int_oe_n
);
    logic rst_s1_q, rst_n;
    logic [2:0] scl_q, sda_q;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [21:0] tmr_q, tmr_d;
    logic conv_done;
    lth_i2c_state_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_byte;
    logic rw_q, rw_d, drv_q, drv_d, nack_q, nack_d, wr_en;
    logic [7:0] cfg_q, cfg_d, plo_q, plo_d, phi_q, phi_d;
    logic [7:0] ltl_q, ltl_d, nib_q, nib_d, uth_q, uth_d, prox_q, prox_d;
    logic [11:0] light_q, light_d, upper_thr, lower_thr;
    logic ictl_q, ictl_d, lflag_q, lflag_d, pflag_q, pflag_d;
    lth_persist_t lper_q, lper_d, pper_q, pper_d;
    logic int_q, int_d;
    lth_flt_if f_light ();
    lth_flt_if f_pset ();
    lth_flt_if f_pclr ();

    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], i_scl};
            sda_q <= {sda_q[1:0], i_sda};
        end
    end

    assign scl_rise = scl_q[1] && !scl_q[2];
    assign scl_fall = !scl_q[1] && scl_q[2];
    assign bus_start = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
    assign bus_stop = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];

    // ****************************************
    // integration timer
    // ****************************************
    always_comb begin
        conv_done = (tmr_q == 22'(P_INTEG_CYCLES - 1));
        tmr_d = conv_done ? 22'h000000 : tmr_q + 22'h000001;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tmr_q <= 22'h000000;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // ****************************************
    // serial target
    // ****************************************
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        drv_d = drv_q;
        nack_d = nack_q;
        wr_en = 1'b0;
        if (bus_start) begin
            st_d = LTH_ADDR;
            cnt_d = 4'h0;
            drv_d = 1'b0;
        end else if (bus_stop) begin
            st_d = LTH_IDLE;
            drv_d = 1'b0;
        end else if (scl_rise) begin
            if (st_q == LTH_ADDR || st_q == LTH_REG || st_q == LTH_WDATA) begin
                sh_d = {sh_q[6:0], sda_q[1]};
                cnt_d = cnt_q + 4'h1;
            end else if (st_q == LTH_RDATA_ACK) begin
                nack_d = sda_q[1];
            end
        end else if (scl_fall) begin
            unique case (st_q)
                LTH_IDLE: begin
                    drv_d = 1'b0;
                end
                LTH_ADDR, LTH_REG, LTH_WDATA: begin
                    if (cnt_q == 4'h8) begin
                        drv_d = 1'b1;
                        if (st_q == LTH_ADDR) begin
                            if (sh_q[7:1] == `LTH_I2C_ADDR) begin
                                st_d = LTH_ADDR_ACK;
                                rw_d = sh_q[0];
                            end else begin
                                st_d = LTH_IDLE;
                                drv_d = 1'b0;
                            end
                        end else if (st_q == LTH_REG) begin
                            ptr_d = sh_q;
                            st_d = LTH_REG_ACK;
                        end else begin
                            wr_en = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                            st_d = LTH_WDATA_ACK;
                        end
                    end
                end
                LTH_ADDR_ACK, LTH_RDATA_ACK: begin
                    if ((st_q == LTH_ADDR_ACK && rw_q) ||
                        (st_q == LTH_RDATA_ACK && !nack_q)) begin
                        st_d = LTH_RDATA;
                        sh_d = {rd_byte[6:0], 1'b0};
                        drv_d = !rd_byte[7];
                        cnt_d = 4'h1;
                    end else begin
                        st_d = (st_q == LTH_ADDR_ACK) ? LTH_REG : LTH_IDLE;
                        drv_d = 1'b0;
                        cnt_d = 4'h0;
                    end
                end
                LTH_REG_ACK, LTH_WDATA_ACK: begin
                    st_d = LTH_WDATA;
                    drv_d = 1'b0;
                    cnt_d = 4'h0;
                end
                LTH_RDATA: begin
                    if (cnt_q == 4'h8) begin
                        st_d = LTH_RDATA_ACK;
                        drv_d = 1'b0;
                        ptr_d = ptr_q + 8'h01;
                    end else begin
                        drv_d = !sh_q[7];
                        sh_d = {sh_q[6:0], 1'b0};
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= LTH_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            drv_q <= 1'b0;
            nack_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            drv_q <= drv_d;
            nack_q <= nack_d;
        end
    end

    // ****************************************
    // read multiplexer
    // ****************************************
    always_comb begin
        unique case (ptr_q)
            `LTH_ADDR_CFG: rd_byte = cfg_q;
            `LTH_ADDR_INTR: rd_byte = {pflag_q, pper_q, 1'b0, lflag_q, lper_q,
                                      ictl_q};
            `LTH_ADDR_PROX_LO: rd_byte = plo_q;
            `LTH_ADDR_PROX_HI: rd_byte = phi_q;
            `LTH_ADDR_LT_LOW: rd_byte = ltl_q;
            `LTH_ADDR_NIBBLES: rd_byte = nib_q;
            `LTH_ADDR_UT_HIGH: rd_byte = uth_q;
            `LTH_ADDR_PROX: rd_byte = prox_q;
            `LTH_ADDR_LIGHT_LO: rd_byte = light_q[7:0];
            `LTH_ADDR_LIGHT_HI: rd_byte = {4'h0, light_q[11:8]};
            default: rd_byte = 8'h00;
        endcase
    end

    // ****************************************
    // thresholds and filters
    // ****************************************
    assign upper_thr = {uth_q, nib_q[7:4]};
    assign lower_thr = {nib_q[3:0], ltl_q};
    assign f_light.conv_done = conv_done;
    assign f_light.cond = (i_light_adc >= upper_thr) ||
                          (i_light_adc <= lower_thr);
    assign f_light.sel = lper_q;
    assign f_pset.conv_done = conv_done;
    assign f_pset.cond = (i_prox_adc >= phi_q);
    assign f_pset.sel = pper_q;
    assign f_pclr.conv_done = conv_done;
    assign f_pclr.cond = (i_prox_adc <= plo_q);
    assign f_pclr.sel = pper_q;

    lth_persist u_light (.i_clk_sys(i_clk_sys), .i_rst_n(rst_n), .f(f_light));
    lth_persist u_pset (.i_clk_sys(i_clk_sys), .i_rst_n(rst_n), .f(f_pset));
    lth_persist u_pclr (.i_clk_sys(i_clk_sys), .i_rst_n(rst_n), .f(f_pclr));

    // ****************************************
    // register file
    // ****************************************
    always_comb begin
        cfg_d = cfg_q;
        plo_d = plo_q;
        phi_d = phi_q;
        ltl_d = ltl_q;
        nib_d = nib_q;
        uth_d = uth_q;
        ictl_d = ictl_q;
        lper_d = lper_q;
        pper_d = pper_q;
        lflag_d = lflag_q;
        pflag_d = pflag_q;
        prox_d = prox_q;
        light_d = light_q;
        if (wr_en) begin
            unique case (ptr_q)
                `LTH_ADDR_CFG: cfg_d = sh_q;
                `LTH_ADDR_INTR: begin
                    ictl_d = sh_q[`LTH_INT_CTRL];
                    lper_d = sh_q[2:1];
                    pper_d = sh_q[6:5];
                    if (!sh_q[`LTH_INT_LFLAG]) begin
                        lflag_d = 1'b0;
                    end
                    if (!sh_q[`LTH_INT_PFLAG]) begin
                        pflag_d = 1'b0;
                    end
                end
                `LTH_ADDR_PROX_LO: plo_d = sh_q;
                `LTH_ADDR_PROX_HI: phi_d = sh_q;
                `LTH_ADDR_LT_LOW: ltl_d = sh_q;
                `LTH_ADDR_NIBBLES: nib_d = sh_q;
                `LTH_ADDR_UT_HIGH: uth_d = sh_q;
                default: begin
                    cfg_d = cfg_q; // result registers ignore writes
                end
            endcase
        end
        if (conv_done) begin
            prox_d = i_prox_adc;
            light_d = i_light_adc;
        end
        if (f_pclr.hit) begin
            pflag_d = 1'b0;
        end
        if (f_pset.hit) begin
            pflag_d = 1'b1;
        end
        if (f_light.hit) begin
            lflag_d = 1'b1; // set beats clear
        end
        int_d = ictl_d ? (lflag_d && pflag_d) : (lflag_d || pflag_d);
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `LTH_RST_ZERO;
            plo_q <= `LTH_RST_ZERO;
            phi_q <= `LTH_RST_PROX_HI;
            ltl_q <= `LTH_RST_ZERO;
            nib_q <= `LTH_RST_NIBBLES;
            uth_q <= `LTH_RST_UT_HIGH;
            ictl_q <= 1'b0;
            lper_q <= 2'h0;
            pper_q <= 2'h0;
            lflag_q <= 1'b0;
            pflag_q <= 1'b0;
            prox_q <= `LTH_RST_ZERO;
            light_q <= 12'h000;
            int_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            plo_q <= plo_d;
            phi_q <= phi_d;
            ltl_q <= ltl_d;
            nib_q <= nib_d;
            uth_q <= uth_d;
            ictl_q <= ictl_d;
            lper_q <= lper_d;
            pper_q <= pper_d;
            lflag_q <= lflag_d;
            pflag_q <= pflag_d;
            prox_q <= prox_d;
            light_q <= light_d;
            int_q <= int_d;
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = !drv_q;
    assign o_int_out = 1'b0;
    assign o_int_oe_n = !int_q;
    assign o_conv_done = conv_done;
    assign o_light_range_high = cfg_q[`LTH_CFG_RANGE];
    assign o_light_ir_mode = cfg_q[`LTH_CFG_IRMODE];

    // ****************************************
    // checks
    // ****************************************
    sequence s_addr_byte;
        st_q == LTH_ADDR && scl_fall && !bus_start && !bus_stop &&
            cnt_q == 4'h8;
    endsequence
    sequence s_conv_above;
        conv_done && lper_q == 2'h0 && i_light_adc >= upper_thr;
    endsequence
    sequence s_conv_below;
        conv_done && lper_q == 2'h0 && i_light_adc <= lower_thr;
    endsequence

    a_upper_flag_set: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) s_conv_above |=> lflag_q ##1
        (lflag_q || $past(wr_en && ptr_q == `LTH_ADDR_INTR)))
        else $error("light flag not set above upper threshold");
    a_lower_flag_set: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) s_conv_below |=> lflag_q)
        else $error("light flag not set below lower threshold");
    a_upper_thr_load: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) wr_en && ptr_q == `LTH_ADDR_UT_HIGH |=>
        upper_thr[11:4] == $past(sh_q))
        else $error("upper threshold high byte not loaded");
    a_prox_read_only: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) wr_en && ptr_q == `LTH_ADDR_PROX && !conv_done
        |=> $stable(prox_q))
        else $error("proximity result changed by a write");
    a_result_refresh: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) conv_done |=>
        light_q == $past(i_light_adc) && prox_q == $past(i_prox_adc))
        else $error("results not refreshed at conversion end");
    a_light_high_nib: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) ptr_q == `LTH_ADDR_LIGHT_HI |->
        rd_byte[7:4] == 4'h0 && rd_byte[3:0] == light_q[11:8])
        else $error("light high byte mapped wrongly");
    a_integ_spacing: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) conv_done |-> tmr_q == 22'(P_INTEG_CYCLES - 1)
        ##1 tmr_q == 22'h000000)
        else $error("integration period wrong");
    a_addr_match: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) s_addr_byte |=>
        (drv_q == (sh_q[7:1] == `LTH_I2C_ADDR)) ##1 1'b1)
        else $error("address acknowledge wrong");
    a_flag_sticky: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) lflag_q && !(wr_en && ptr_q == `LTH_ADDR_INTR)
        |=> lflag_q)
        else $error("light flag dropped without a write");
    a_int_and_mode: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n) ictl_q && !(lflag_q && pflag_q) && $stable(ictl_q)
        && $stable(lflag_q) && $stable(pflag_q) |-> o_int_oe_n)
        else $error("interrupt pin low in AND mode with one flag");
endmodule // lth_light_regs
`default_nettype wire

// [tb/lth_host.sv]
// Purpose: serial-bus host model for the light block
// Assumes: bus wire has a pull-up; scl high 8 clocks and low 16 clocks per bit
// Notes: drives at rising edges only
`timescale 1ns/1ps
`default_nettype none
module lth_host (
    // bus
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    localparam logic [6:0] P_ADDR = 7'h44;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic half();
        repeat (8) @(posedge i_clk_sys);
    endtask
    task automatic start();
        o_sda_low <= 1'b0;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= 1'b1;
        half();
        o_scl <= 1'b0;
        half();
    endtask
    task automatic stop();
        o_sda_low <= 1'b1;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= 1'b0;
        half();
    endtask
    task automatic tx_bit(input logic b, output logic r);
        o_sda_low <= ~b;
        half();
        o_scl <= 1'b1;
        half();
        r = i_sda;
        o_scl <= 1'b0;
        half();
    endtask
    // n is the ninth bit sent: 1 releases, 0 acks
    task automatic xfer(input logic [7:0] d, input logic n,
                        output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) tx_bit(d[i], q[i]);
        tx_bit(n, a);
    endtask
    task automatic write_reg(input logic [7:0] r, input logic [7:0] d);
        logic [7:0] q;
        logic a;
        start();
        xfer({P_ADDR, 1'b0}, 1'b1, q, a);
        xfer(r, 1'b1, q, a);
        xfer(d, 1'b1, q, a);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] r, output logic [7:0] d);
        logic [7:0] q;
        logic a;
        start();
        xfer({P_ADDR, 1'b0}, 1'b1, q, a);
        xfer(r, 1'b1, q, a);
        start();
        xfer({P_ADDR, 1'b1}, 1'b1, q, a);
        xfer(8'hff, 1'b1, d, a);
        stop();
    endtask
    task automatic probe(input logic [6:0] ad, output logic a);
        logic [7:0] q;
        start();
        xfer({ad, 1'b0}, 1'b1, q, a);
        stop();
    endtask
endmodule // lth_host
`default_nettype wire

// [tb/tb_light_threshold_data_regs.sv]
// Purpose: self-checking bench of the light register block
// Assumes: short conversion period
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module tb_light_threshold_data_regs;
    localparam int unsigned P_PER = 200;
    logic i_clk_sys, i_arst_n, ack;
    logic [11:0] light;
    logic [7:0] prox;
    int fail_count, cmp_count, cyc, n;
    wire logic scl, sda_low, sda, oe_n, done, rng, irm, int_oe_n;
    wire logic sda_out, int_out, int_pin;
    assign sda = !sda_low && (oe_n || sda_out);
    assign int_pin = int_oe_n || int_out;
    lth_light_regs #(.P_INTEG_CYCLES(P_PER)) uut (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(oe_n),
        .i_light_adc(light), .i_prox_adc(prox), .o_conv_done(done),
        .o_light_range_high(rng), .o_light_ir_mode(irm),
        .o_int_out(int_out), .o_int_oe_n(int_oe_n));
    lth_host host (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl),
        .o_sda_low(sda_low));
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic conv();
        repeat (2 * P_PER + 8) @(posedge i_clk_sys);
    endtask
    initial begin
        i_arst_n = 1'b0;
        light = 12'h000;
        prox = 8'h00;
        repeat (8) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        rchk(8'h06, 8'hf0);
        rchk(8'h07, 8'hff);
        rchk(8'h08, 8'h00);
        rchk(8'h09, 8'h00);
        rchk(8'h0a, 8'h00);
        $display("test reset done");
        for (n = 0; n < 1000 && !done; n++) @(posedge i_clk_sys);
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (!done && n < 1000);
        chk("period", P_PER[7:0], n[7:0]);
        $display("test period done");
        host.write_reg(8'h06, 8'h50);
        host.write_reg(8'h07, 8'h12);
        rchk(8'h06, 8'h50);
        rchk(8'h07, 8'h12);
        light <= 12'h124;
        conv();
        host.write_reg(8'h02, 8'h00);
        conv();
        rchk(8'h02, 8'h00);
        chk("int pin", 8'h01, {7'h0, int_pin});
        light <= 12'h125;
        conv();
        rchk(8'h02, 8'h08);
        chk("int pin", 8'h00, {7'h0, int_pin});
        light <= 12'h124;
        conv();
        rchk(8'h02, 8'h08);
        host.write_reg(8'h02, 8'h00);
        rchk(8'h02, 8'h00);
        host.write_reg(8'h05, 8'h30);
        light <= 12'h030;
        conv();
        rchk(8'h02, 8'h08);
        $display("test thresholds done");
        light <= 12'habc;
        prox <= 8'h5d;
        conv();
        rchk(8'h08, 8'h5d);
        rchk(8'h09, 8'hbc);
        rchk(8'h0a, 8'h0a);
        host.write_reg(8'h08, 8'hff);
        host.write_reg(8'h09, 8'h00);
        rchk(8'h08, 8'h5d);
        rchk(8'h09, 8'hbc);
        $display("test results done");
        host.write_reg(8'h02, 8'h01);
        conv();
        chk("int pin", 8'h01, {7'h0, int_pin});
        rchk(8'h02, 8'h09);
        prox <= 8'hff;
        conv();
        chk("int pin", 8'h00, {7'h0, int_pin});
        rchk(8'h02, 8'h89);
        $display("test and mode done");
        host.write_reg(8'h01, 8'h02);
        chk("range pin", 8'h01, {7'h0, rng});
        chk("ir mode pin", 8'h00, {7'h0, irm});
        rchk(8'h01, 8'h02);
        host.write_reg(8'h01, 8'h01);
        chk("range pin", 8'h00, {7'h0, rng});
        chk("ir mode pin", 8'h01, {7'h0, irm});
        $display("test range done");
        host.probe(7'h45, ack);
        chk("ack other", 8'h01, {7'h0, ack});
        host.probe(7'h44, ack);
        chk("ack own", 8'h00, {7'h0, ack});
        $display("test address done");
        print_verdict();
    end
endmodule // tb_light_threshold_data_regs
`default_nettype wire
